// file: design/aat_top.v
// Purpose: Conversion start, sample FIFO and six counters of the analog input
// Assumes: Converter signals and connector pins are asynchronous
// Notes: Two byte/word I/O regions with separate strobes
`include "aat_regs.vh"
// Functional notes
// - Source 00: any result write starts one conversion unless acquisition is halted
// - Done visible via live flag or FIFO not-empty indication
// - Result read gives 12 bits, upper four bits zero
// - Bipolar results are offset binary, passed unchanged
// - Unipolar results are straight binary, passed unchanged
// - Any write to FIFO clear empties the FIFO
// - Counter region decodes byte accesses only
// - Residual counter halts acquisition at terminal count, mode 0
// - Residual counter counts only once arm is set
// - Pacer is 10MHz-clocked low counter cascaded into high counter
// - High divider output is internal pacer, mode 2
// - Counts load as low byte then high byte
// - Outside pre-trigger index counter is a user counter
// - Pre-trigger: trigger latch gates on, half-full gates off
// - Two user counters clocked from connector only
// - Source select: software, pacer, falling edge, rising edge
// - Done flag is live end-of-conversion copy
// - FIFO holds 1024 results
module aat_top #(
	parameter DEPTH = `AAT_FIFO_DEPTH,
	parameter AW = `AAT_FIFO_AW
) (
	// Clock and reset
	input wire clk_sys_i,
	input wire rstn_i,
	// Conversion region, word access
	input wire conv_wr_i,
	input wire conv_rd_i,
	input wire [3:0] conv_addr_i,
	input wire [15:0] conv_wdata_i,
	output reg [15:0] conv_rdata_o,
	// Counter region, byte access
	input wire cnt_wr_i,
	input wire cnt_rd_i,
	input wire cnt_byte_i,
	input wire [3:0] cnt_addr_i,
	input wire [7:0] cnt_wdata_i,
	output reg [7:0] cnt_rdata_o,
	// Control bits from the trigger and control registers
	input wire [1:0] pacer_source_select_i,
	input wire pretrigger_mode_i,
	input wire arm_i,
	input wire index_counter_clock_select_i,
	input wire external_trigger_latch_i,
	// Converter
	output reg conv_start_o,
	input wire conv_eoc_i,
	input wire [11:0] conv_data_i,
	input wire conv_valid_i,
	input wire ext_pacer_i,
	// Status
	output wire conversion_done_o,
	output wire fifo_not_empty_irq_o,
	output wire fifo_half_full_o,
	output reg acq_halt_o,
	output wire internal_pacer_o,
	// User counters on the connector
	input wire [2:0] user_clk_i,
	input wire [2:0] user_gate_i,
	output wire [2:0] user_out_o
);
	localparam NSYNC = 12;
	localparam integer REF_LAST = `AAT_REF_DIV - 1;
	reg rst_s1_reg;
	reg rst_n;
	reg [NSYNC-1:0] s1_reg;
	reg [NSYNC-1:0] s2_reg;
	reg [NSYNC-1:0] s3_reg;
	reg [4:0] ref_cnt_reg;
	reg ref_en_reg;
	reg [11:0] fifo_mem [0:DEPTH-1];
	reg [AW:0] wr_ptr_reg;
	reg [AW:0] rd_ptr_reg;
	reg [11:0] dat_s1_reg;
	reg [11:0] dat_s2_reg;
	reg pacer_q_reg;
	reg resid_q_reg;
	reg idx_gate_reg;
	reg low_q_reg;
	wire pacer_q_low;
	wire [NSYNC-1:0] raw;
	wire [NSYNC-1:0] rise;
	wire [NSYNC-1:0] fall;
	wire [AW:0] level;
	wire push;
	wire pop;
	wire clr;
	wire cnt_acc_wr;
	wire cnt_acc_rd;
	wire ctrl_wr;
	wire [1:0] ctrl_sel;
	wire [5:0] cwr;
	wire [5:0] crd;
	wire [5:0] cen;
	wire [5:0] cgate;
	wire [5:0] cout;
	wire [47:0] crdata;
	wire [7:0] ucnt_ctrl_wr;
	wire pacer_tick;
	wire ext_tick;
	wire start_evt;
	assign raw = {ext_pacer_i, conv_valid_i, conv_eoc_i, user_gate_i,
		user_clk_i, external_trigger_latch_i, arm_i, pretrigger_mode_i};
	// Reset release through two flops
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= {NSYNC{1'b0}};
			s2_reg <= {NSYNC{1'b0}};
			s3_reg <= {NSYNC{1'b0}};
			dat_s1_reg <= 12'h000;
			dat_s2_reg <= 12'h000;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			dat_s1_reg <= conv_data_i;
			dat_s2_reg <= dat_s1_reg;
		end
	end
	assign rise = s2_reg & ~s3_reg;
	assign fall = ~s2_reg & s3_reg;
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_reg <= 5'h00;
			ref_en_reg <= 1'b0;
		end else if (ref_cnt_reg == REF_LAST[4:0]) begin
			ref_cnt_reg <= 5'h00;
			ref_en_reg <= 1'b1;
		end else begin
			ref_cnt_reg <= ref_cnt_reg + 5'h01;
			ref_en_reg <= 1'b0;
		end
	end
	assign conversion_done_o = s2_reg[9];
	assign pacer_tick = cout[2] & ~pacer_q_reg;
	assign ext_tick = (pacer_source_select_i == `AAT_SRC_EXT_FALL) ?
		fall[11] : rise[11];
	assign start_evt =
		(pacer_source_select_i == `AAT_SRC_SOFTWARE) ?
			(conv_wr_i && conv_addr_i == `AAT_CONV_RESULT_OFS) :
		(pacer_source_select_i == `AAT_SRC_PACER) ? pacer_tick :
		ext_tick;
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			conv_start_o <= 1'b0;
			pacer_q_reg <= 1'b0;
			resid_q_reg <= 1'b0;
			acq_halt_o <= 1'b0;
		end else begin
			pacer_q_reg <= cout[2];
			resid_q_reg <= cout[0];
			conv_start_o <= start_evt & ~acq_halt_o;
			// halt at residual terminal count, set wins
			if (cout[0] && !resid_q_reg && s2_reg[1])
				acq_halt_o <= 1'b1;
			else if (clr)
				acq_halt_o <= 1'b0;
		end
	end
	assign level = wr_ptr_reg - rd_ptr_reg;
	assign push = rise[10] && (level != DEPTH[AW:0]);
	assign pop = conv_rd_i && conv_addr_i == `AAT_CONV_RESULT_OFS &&
		level != {(AW+1){1'b0}};
	assign clr = conv_wr_i && conv_addr_i == `AAT_FIFO_CLEAR_OFS;
	// completion seen as a stored word
	assign fifo_not_empty_irq_o = (level != {(AW+1){1'b0}});
	assign fifo_half_full_o = (level >= (DEPTH[AW:0] >> 1));
	always @(posedge clk_sys_i) begin
		if (push)
			fifo_mem[wr_ptr_reg[AW-1:0]] <= dat_s2_reg;
	end
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
			conv_rdata_o <= 16'h0000;
		end else if (clr) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				conv_rdata_o <= {4'h0, fifo_mem[rd_ptr_reg[AW-1:0]]};
			end
		end
	end
	assign cnt_acc_wr = cnt_wr_i & cnt_byte_i;
	assign cnt_acc_rd = cnt_rd_i & cnt_byte_i;
	assign ctrl_wr = cnt_acc_wr && (cnt_addr_i == `AAT_ACQ_CTRL_OFS ||
		cnt_addr_i == `AAT_UCNT_CTRL_OFS);
	assign ctrl_sel = cnt_wdata_i[7:6];
	assign ucnt_ctrl_wr = {8{cnt_addr_i == `AAT_UCNT_CTRL_OFS}};
	// index gate on by trigger, off by half-full
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n)
			idx_gate_reg <= 1'b0;
		else if (clr || !s2_reg[0])
			idx_gate_reg <= 1'b0;
		else if (fifo_half_full_o)
			idx_gate_reg <= 1'b0;
		else if (rise[2])
			idx_gate_reg <= 1'b1;
	end
	// residual counts on conversions after arm
	assign cen[0] = rise[10];
	assign cgate[0] = s2_reg[1];
	assign cen[1] = ref_en_reg;
	assign cgate[1] = 1'b1;
	// upper counter clocked by lower output
	assign cen[2] = ~cout[1] & pacer_q_low;
	assign cgate[2] = 1'b1;
	assign cen[3] = s2_reg[0] ? rise[10] :
		(index_counter_clock_select_i ? ref_en_reg : rise[3]);
	assign cgate[3] = s2_reg[0] ? idx_gate_reg : s2_reg[6];
	assign cen[4] = rise[4];
	assign cgate[4] = s2_reg[7];
	assign cen[5] = rise[5];
	assign cgate[5] = s2_reg[8];
	assign internal_pacer_o = cout[2];
	assign user_out_o = cout[5:3];
	// Falling edge of the lower divider output
	assign pacer_q_low = low_q_reg;
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n)
			low_q_reg <= 1'b0;
		else
			low_q_reg <= cout[1];
	end
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_cnt
			wire bank;
			wire hit;
			assign bank = (g >= 3);
			assign hit = (cnt_addr_i == (bank ? 4'h8 + g - 3 : 4'h0 + g));
			assign cwr[g] = cnt_acc_wr && hit;
			assign crd[g] = cnt_acc_rd && hit;
			aat_counter #(.WIDTH(16)) u_cnt (
				.clk_sys_i(clk_sys_i),
				.rst_n_i(rst_n),
				.mode_wr_i(ctrl_wr && ctrl_sel == (g % 3) &&
					ucnt_ctrl_wr[g] == bank),
				.mode_i(cnt_wdata_i[3:1]),
				.data_wr_i(cwr[g]),
				.data_rd_i(crd[g]),
				.data_i(cnt_wdata_i),
				.data_o(crdata[8*g +: 8]),
				.cnt_en_i(cen[g]),
				.gate_i(cgate[g]),
				.out_o(cout[g])
			);
		end
	endgenerate
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n)
			cnt_rdata_o <= 8'h00;
		else if (cnt_acc_rd) begin
			case (cnt_addr_i)
			`AAT_RESIDUAL_OFS: cnt_rdata_o <= crdata[7:0];
			`AAT_PACER_LOW_OFS: cnt_rdata_o <= crdata[15:8];
			`AAT_PACER_HIGH_OFS: cnt_rdata_o <= crdata[23:16];
			`AAT_INDEX_CNT_OFS: cnt_rdata_o <= crdata[31:24];
			`AAT_USER_B_OFS: cnt_rdata_o <= crdata[39:32];
			`AAT_USER_C_OFS: cnt_rdata_o <= crdata[47:40];
			default: cnt_rdata_o <= 8'h00;
			endcase
		end
	end
endmodule

// file: design/aat_regs.vh
// Purpose: Offsets, fields and timing constants of the acquisition timing block
// Assumes: Byte addresses within each I/O region
// Notes: Definitions only
`ifndef AAT_REGS_VH
`define AAT_REGS_VH
`define AAT_CONV_RESULT_OFS 4'h0
`define AAT_FIFO_CLEAR_OFS 4'h2
`define AAT_RESIDUAL_OFS 4'h0
`define AAT_PACER_LOW_OFS 4'h1
`define AAT_PACER_HIGH_OFS 4'h2
`define AAT_ACQ_CTRL_OFS 4'h3
`define AAT_INDEX_CNT_OFS 4'h8
`define AAT_USER_B_OFS 4'h9
`define AAT_USER_C_OFS 4'ha
`define AAT_UCNT_CTRL_OFS 4'hb
`define AAT_SRC_SOFTWARE 2'h0
`define AAT_SRC_PACER 2'h1
`define AAT_SRC_EXT_FALL 2'h2
`define AAT_SRC_EXT_RISE 2'h3
`define AAT_FIFO_DEPTH 1024
`define AAT_FIFO_AW 10
`define AAT_SYS_CLK_HZ 200000000
`define AAT_REF_CLK_HZ 10000000
`define AAT_REF_DIV (`AAT_SYS_CLK_HZ / `AAT_REF_CLK_HZ)
`endif

// file: design/aat_counter.v
// Purpose: One 16-bit down counter with byte-wide load, modes 0 and 2
// Assumes: Clock edges arrive as one-cycle enables in the system domain
// Notes: Mode byte bits 3:1 select the mode; mode 6 behaves as mode 2, others as mode 0
`include "aat_regs.vh"
module aat_counter #(
	parameter WIDTH = 16
) (
	// System
	input wire clk_sys_i,
	input wire rst_n_i,
	// Host side
	input wire mode_wr_i,
	input wire [2:0] mode_i,
	input wire data_wr_i,
	input wire data_rd_i,
	input wire [7:0] data_i,
	output wire [7:0] data_o,
	// Counting side
	input wire cnt_en_i,
	input wire gate_i,
	output reg out_o
);
	reg [2:0] mode_reg;
	reg [WIDTH-1:0] count_reg;
	reg [WIDTH-1:0] reload_reg;
	reg [7:0] low_reg;
	reg hi_next_reg;
	reg rd_hi_reg;
	reg loaded_reg;
	wire auto_reload;
	assign auto_reload = (mode_reg[1:0] == 2'b10);
	assign data_o = rd_hi_reg ? count_reg[15:8] : count_reg[7:0];
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_reg <= 3'h0;
			count_reg <= {WIDTH{1'b0}};
			reload_reg <= {WIDTH{1'b0}};
			low_reg <= 8'h00;
			hi_next_reg <= 1'b0;
			rd_hi_reg <= 1'b0;
			loaded_reg <= 1'b0;
			out_o <= 1'b0;
		end else begin
			if (mode_wr_i) begin
				mode_reg <= mode_i;
				hi_next_reg <= 1'b0;
				rd_hi_reg <= 1'b0;
				loaded_reg <= 1'b0;
				out_o <= (mode_i[1:0] == 2'b10);
			end else if (data_wr_i) begin
				if (!hi_next_reg) begin
					low_reg <= data_i;
					hi_next_reg <= 1'b1;
				end else begin
					count_reg <= {data_i, low_reg};
					reload_reg <= {data_i, low_reg};
					hi_next_reg <= 1'b0;
					loaded_reg <= 1'b1;
					out_o <= auto_reload;
				end
			end else begin
				if (data_rd_i)
					rd_hi_reg <= ~rd_hi_reg;
				if (cnt_en_i && gate_i && loaded_reg) begin
					if (auto_reload) begin
						if (count_reg == 16'h0002) begin
							out_o <= 1'b0;
							count_reg <= count_reg - 16'h0001;
						end else if (count_reg <= 16'h0001) begin
							out_o <= 1'b1;
							count_reg <= reload_reg;
						end else begin
							out_o <= 1'b1;
							count_reg <= count_reg - 16'h0001;
						end
					end else begin
						count_reg <= count_reg - 16'h0001;
						if (count_reg == 16'h0001)
							out_o <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// file: tb/aat_chk.sv
// Purpose: Port checker for aat_top
// Assumes: Converter model answers each start
// Notes: Counter timing is left to the bench
module aat_chk (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic conv_wr_i,
	input wire logic [3:0] conv_addr_i,
	input wire logic [1:0] pacer_source_select_i,
	input wire logic conv_eoc_i,
	input wire logic conv_valid_i,
	input wire logic [15:0] conv_rdata_o,
	input wire logic conv_start_o,
	input wire logic conversion_done_o,
	input wire logic fifo_not_empty_irq_o,
	input wire logic fifo_half_full_o,
	input wire logic acq_halt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	sequence s_sw_start;
		conv_wr_i && conv_addr_i == 4'h0 && pacer_source_select_i == 2'h0
			&& !acq_halt_o;
	endsequence
	sequence s_clear;
		conv_wr_i && conv_addr_i == 4'h2;
	endsequence
	a_sw_start: assert property (s_sw_start |=> conv_start_o)
		else $error("no start after result write");
	a_start_cause: assert property (conv_start_o |->
		($past(conv_wr_i) && $past(conv_addr_i) == 4'h0) ||
		$past(pacer_source_select_i) != 2'h0)
		else $error("start without a cause");
	a_upper_zero: assert property (conv_rdata_o[15:12] == 4'h0)
		else $error("result upper bits not zero");
	a_done_high: assert property (conv_eoc_i [*8] |-> conversion_done_o)
		else $error("done flag not following converter");
	a_done_low: assert property (!conv_eoc_i [*8] |-> !conversion_done_o)
		else $error("done flag high while busy");
	a_clear_empty: assert property (s_clear |=> !fifo_not_empty_irq_o)
		else $error("fifo not empty after clear");
	a_half_nonempty: assert property (fifo_half_full_o |->
		fifo_not_empty_irq_o)
		else $error("half full while empty");
	a_halt_block: assert property (acq_halt_o [*2] |-> !conv_start_o)
		else $error("start while halted");
	a_push_shows: assert property ($rose(conv_valid_i) |-> ##[1:5]
		(fifo_not_empty_irq_o || conv_wr_i))
		else $error("stored word not indicated");
endmodule
bind aat_top aat_chk aat_chk_i (.clk_sys_i, .rstn_i, .conv_wr_i,
	.conv_addr_i, .pacer_source_select_i, .conv_eoc_i, .conv_valid_i,
	.conv_rdata_o, .conv_start_o, .conversion_done_o,
	.fifo_not_empty_irq_o, .fifo_half_full_o, .acq_halt_o);

// file: tb/aat_adc_model.sv
// Purpose: Behavioural converter answering each start pulse
// Assumes: Starts that arrive while busy are ignored
// Notes: Data shows the inverse outside its valid window
module aat_adc_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [11:0] sample_i,
	output logic eoc_o = 1'b1,
	output logic valid_o = 1'b0,
	output logic [11:0] data_o = 12'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clk_i) begin
		if (start_i) begin
			eoc_o <= 1'b0;
			data_o <= ~sample_i;
			repeat (12) @(posedge clk_i);
			data_o <= sample_i;
			@(posedge clk_i);
			eoc_o <= 1'b1;
			valid_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			valid_o <= 1'b0;
			data_o <= ~sample_i;
		end
	end
endmodule

// file: tb/test_aat_top.sv
// Purpose: Directed bench for aat_top
// Assumes: FIFO depth shrunk to 8
// Notes: Inputs change on the falling edge
module test_aat_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0, rstn_i = 1'b0;
	logic conv_wr_i = 1'b0, conv_rd_i = 1'b0, cnt_wr_i = 1'b0;
	logic cnt_rd_i = 1'b0, cnt_byte_i = 1'b0, arm_i = 1'b0;
	logic [3:0] conv_addr_i = '0, cnt_addr_i = '0;
	logic [15:0] conv_wdata_i = '0;
	logic [7:0] cnt_wdata_i = '0;
	logic [1:0] pacer_source_select_i = '0;
	logic pretrigger_mode_i = 1'b0, index_counter_clock_select_i = 1'b0;
	logic external_trigger_latch_i = 1'b0, ext_pacer_i = 1'b0;
	logic [2:0] user_clk_i = '0, user_gate_i = '1;
	logic [11:0] smp = '0;
	logic [11:0] tbl [4] = '{12'h000, 12'h7ff, 12'hfff, 12'h800};
	wire [15:0] conv_rdata_o;
	wire [7:0] cnt_rdata_o;
	wire [11:0] conv_data_i;
	wire [2:0] user_out_o;
	wire conv_start_o, conv_eoc_i, conv_valid_i, conversion_done_o;
	wire fifo_not_empty_irq_o, fifo_half_full_o, acq_halt_o;
	wire internal_pacer_o;
	int n_fail = 0, checks = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	aat_top #(.DEPTH(8), .AW(3)) aat_top_i (.clk_sys_i, .rstn_i,
		.conv_wr_i, .conv_rd_i, .conv_addr_i, .conv_wdata_i, .conv_rdata_o,
		.cnt_wr_i, .cnt_rd_i, .cnt_byte_i, .cnt_addr_i, .cnt_wdata_i,
		.cnt_rdata_o, .pacer_source_select_i, .pretrigger_mode_i, .arm_i,
		.index_counter_clock_select_i, .external_trigger_latch_i,
		.conv_start_o, .conv_eoc_i, .conv_data_i, .conv_valid_i,
		.ext_pacer_i, .conversion_done_o, .fifo_not_empty_irq_o,
		.fifo_half_full_o, .acq_halt_o, .internal_pacer_o, .user_clk_i,
		.user_gate_i, .user_out_o);
	aat_adc_model aat_adc_model_i (.clk_i(clk_sys_i), .start_i(conv_start_o),
		.sample_i(smp), .eoc_o(conv_eoc_i), .valid_o(conv_valid_i),
		.data_o(conv_data_i));
	task close_out;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task cw(input logic [3:0] a, input logic rd);
		@(negedge clk_sys_i);
		conv_addr_i = a;
		conv_wdata_i = 16'hc3a5;
		conv_wr_i = !rd;
		conv_rd_i = rd;
		@(negedge clk_sys_i);
		conv_wr_i = 1'b0;
		conv_rd_i = 1'b0;
	endtask
	task bw(input logic [3:0] a, input logic [7:0] d, input logic b);
		@(negedge clk_sys_i);
		cnt_addr_i = a;
		cnt_wdata_i = d;
		cnt_byte_i = b;
		cnt_wr_i = 1'b1;
		@(negedge clk_sys_i);
		cnt_wr_i = 1'b0;
	endtask
	task br(input logic [3:0] a);
		@(negedge clk_sys_i);
		cnt_addr_i = a;
		cnt_byte_i = 1'b1;
		cnt_rd_i = 1'b1;
		@(negedge clk_sys_i);
		cnt_rd_i = 1'b0;
	endtask
	task wt(input logic v, input int n);
		for (int i = 0; i < n && conversion_done_o !== v; i++)
			@(negedge clk_sys_i);
		chk("done", 16'(conversion_done_o), 16'(v));
		if (conversion_done_o !== v)
			close_out;
	endtask
	task wst(input int n);
		for (int i = 0; i < n && conv_start_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		chk("start", 16'(conv_start_o), 16'h1);
		if (conv_start_o !== 1'b1)
			close_out;
		wt(1'b1, 60);
		repeat (6) @(negedge clk_sys_i);
	endtask
	task conv(input logic [11:0] s);
		smp = s;
		cw(4'h0, 1'b0);
		chk("start", 16'(conv_start_o), 16'h1);
		@(negedge clk_sys_i);
		chk("start", 16'(conv_start_o), 16'h0);
		wt(1'b0, 40);
		wt(1'b1, 40);
		repeat (6) @(negedge clk_sys_i);
	endtask
	task t_sw;
		cw(4'h2, 1'b0);
		conv(12'h5a3);
		chk("not_empty", 16'(fifo_not_empty_irq_o), 16'h1);
		cw(4'h0, 1'b1);
		chk("result", conv_rdata_o, 16'h05a3);
		chk("not_empty", 16'(fifo_not_empty_irq_o), 16'h0);
	endtask
	task t_order;
		for (int i = 0; i < 9; i++) begin
			conv(tbl[i % 4]);
			chk("half", 16'(fifo_half_full_o), 16'(i >= 3));
		end
		for (int i = 0; i < 8; i++) begin
			cw(4'h0, 1'b1);
			chk("result", conv_rdata_o, {4'h0, tbl[i % 4]});
		end
		chk("not_empty", 16'(fifo_not_empty_irq_o), 16'h0);
	endtask
	task t_src;
		for (int s = 1; s < 4; s++) begin
			pacer_source_select_i = 2'(s);
			cw(4'h0, 1'b0);
			chk("start", 16'(conv_start_o), 16'h0);
		end
		pacer_source_select_i = 2'h2;
		ext_pacer_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		ext_pacer_i = 1'b0;
		wst(10);
		pacer_source_select_i = 2'h3;
		ext_pacer_i = 1'b1;
		wst(10);
		pacer_source_select_i = 2'h0;
		cw(4'h2, 1'b0);
	endtask
	task t_cnt;
		bw(4'hb, 8'h70, 1'b1);
		bw(4'h9, 8'h34, 1'b1);
		bw(4'h9, 8'h56, 1'b0);
		bw(4'h9, 8'h12, 1'b1);
		br(4'h9);
		chk("count_lo", 16'(cnt_rdata_o), 16'h0034);
		br(4'h9);
		chk("count_hi", 16'(cnt_rdata_o), 16'h0012);
		bw(4'hb, 8'h80, 1'b1);
		bw(4'ha, 8'h02, 1'b1);
		bw(4'ha, 8'h00, 1'b1);
		chk("user_out", 16'(user_out_o[2]), 16'h0);
		for (int i = 0; i < 2; i++) begin
			user_clk_i[2] = 1'b1;
			repeat (4) @(negedge clk_sys_i);
			user_clk_i[2] = 1'b0;
			repeat (4) @(negedge clk_sys_i);
			chk("user_out", 16'(user_out_o[2]), 16'(i == 1));
		end
	endtask
	task t_pac;
		int n;
		logic p;
		bw(4'h3, 8'h74, 1'b1);
		bw(4'h1, 8'h02, 1'b1);
		bw(4'h1, 8'h00, 1'b1);
		bw(4'h3, 8'hb4, 1'b1);
		bw(4'h2, 8'h02, 1'b1);
		bw(4'h2, 8'h00, 1'b1);
		n = 0;
		p = internal_pacer_o;
		repeat (800) begin
			@(negedge clk_sys_i);
			n += int'(p && !internal_pacer_o);
			p = internal_pacer_o;
		end
		chk("pacer", 16'(n >= 9 && n <= 11), 16'h1);
		pacer_source_select_i = 2'h1;
		wst(200);
		pacer_source_select_i = 2'h0;
		repeat (30) @(negedge clk_sys_i);
		cw(4'h2, 1'b0);
	endtask
	task t_halt;
		bw(4'h3, 8'h30, 1'b1);
		bw(4'h0, 8'h03, 1'b1);
		bw(4'h0, 8'h00, 1'b1);
		repeat (3) conv(12'h123);
		chk("halt", 16'(acq_halt_o), 16'h0);
		arm_i = 1'b1;
		repeat (3) conv(12'h321);
		chk("halt", 16'(acq_halt_o), 16'h1);
		cw(4'h0, 1'b0);
		chk("start", 16'(conv_start_o), 16'h0);
		cw(4'h2, 1'b0);
		chk("halt", 16'(acq_halt_o), 16'h0);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		t_sw;
		t_order;
		t_src;
		t_cnt;
		t_pac;
		t_halt;
		close_out;
	end
endmodule
